//--- bench/sdcsb_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module sdcsb_host_model
  import sdcsb_pkg::*;
(
  input wire logic i_clk,
  input wire logic [15:0] i_rdata,
  input wire logic i_rvalid,
  output var sdcsb_req_t o_req
);
  initial o_req = '0;
  // Registers are reached only through these serial commands
  task automatic xfer(input sdcsb_cmd_t c, input logic [15:0] w, output logic [15:0] r, output logic v);
    @(negedge i_clk);
    o_req <= '{valid: 1'b1, cmd: c, wdata: w};
    @(negedge i_clk);
    o_req <= '0;
    r = i_rdata;
    v = i_rvalid;
  endtask
endmodule // sdcsb_host_model
`default_nettype wire

//--- bench/sdcsb_status_bkpt_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e, m) begin checks++; if ((g) !== (e)) begin bad_count++; $display("wrong value at %0t: %s", $time, m); end end
module sdcsb_status_bkpt_tb
  import sdcsb_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, uwr = 1'b0, ce = 1'b1, v;
  logic [7:0] uwd = 8'h00, ctl;
  logic [15:0] rdata, r, w;
  logic rvalid, bg, fo, tg, rs, endbg, clks;
  sdcsb_req_t req;
  sdcsb_cpu_t cpu = '0;
  int bad_count = 0, checks = 0, n_bg = 0, n_fo = 0, n_tg = 0, n_rs = 0, c0, c1, c2;

  sdcsb_status_bkpt dut (.I_CLK(clk), .I_SYS_RST(rst), .I_CE(ce), .I_REQ(req), .I_CPU(cpu),
    .I_USER_FRCRST_WR(uwr), .I_USER_WDATA(uwd), .O_RDATA(rdata), .O_RVALID(rvalid), .O_FORCE_BGND(bg),
    .O_BKPT_FORCE(fo), .O_BKPT_TAG(tg), .O_MCU_RESET(rs), .O_ENABLE_DEBUG(endbg), .O_CLK_SEL(clks));
  sdcsb_host_model host (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(req));

  always #12.5 clk = ~clk;
  // Sampled just after the edge so counting never races the posedge register updates
  always @(posedge clk) begin
    #1;
    n_bg += int'(bg);
    n_fo += int'(fo);
    n_tg += int'(tg);
    n_rs += int'(rs);
  end

  function automatic logic [7:0] exp_st(logic [7:0] c, logic dbg, logic lp, logic cf);
    return (c & 8'hB8) | {1'b0, dbg, 3'b000, lp, cf, 1'b0};
  endfunction

  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic rd(input sdcsb_cmd_t c, output logic [15:0] d);
    host.xfer(c, 16'h0000, d, v);
    `CHK(v, 1'b1, "no read answer")
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #(25 * 4000);
    bad_count++;
    report_and_stop();
  end

  initial begin
    void'($urandom(52951));
    cyc(16);
    rst = 1'b0;
    rd(SDCSB_CMD_READ_STATUS, r);
    `CHK(r, 16'h0000, "status after reset")
    rd(SDCSB_CMD_BREAKPOINT_READ_CMD, r);
    `CHK(r, BKPT_RESET_VAL, "bkpt after reset")
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      w = 16'($urandom);
      ctl = (i == 0) ? 8'hFF : w[7:0];
      host.xfer(SDCSB_CMD_WRITE_CONTROL, {8'h00, ctl}, r, v);
      rd(SDCSB_CMD_READ_STATUS, r);
      `CHK(r, {8'h00, exp_st(ctl, 1'b0, 1'b0, 1'b0)}, "status bits written")
      `CHK({endbg, clks}, {ctl[7], ctl[3]}, "control outputs")
      host.xfer(SDCSB_CMD_BREAKPOINT_WRITE_CMD, w, r, v);
      rd(SDCSB_CMD_BREAKPOINT_READ_CMD, r);
      `CHK(r, w, "bkpt readback")
    end
    $display("register test done");
    ce = 1'b0;
    host.xfer(SDCSB_CMD_BREAKPOINT_WRITE_CMD, ~w, r, v);
    ce = 1'b1;
    rd(SDCSB_CMD_BREAKPOINT_READ_CMD, r);
    `CHK(r, w, "bkpt frozen by clock enable")
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    rd(SDCSB_CMD_READ_STATUS, r);
    `CHK(r, 16'h0000, "status after mid-run reset")
    `CHK({endbg, clks}, 2'b00, "control outputs after mid-run reset")
    $display("enable and reset test done");
    for (int i = 0; i < 5; i++) begin
      ctl = (i == 4) ? 8'hB0 : {2'b10, i[1], i[0], 4'h0};
      w = 16'($urandom);
      host.xfer(SDCSB_CMD_WRITE_CONTROL, {8'h00, ctl}, r, v);
      cpu.in_debug = 1'b1;
      host.xfer(SDCSB_CMD_BREAKPOINT_WRITE_CMD, w, r, v);
      cpu.in_debug = 1'b0;
      c0 = n_fo;
      c1 = n_tg;
      cpu.addr = (i == 4) ? ~w : w;
      {cpu.addr_valid, cpu.opcode_fetch} = 2'b11;
      cyc(1);
      {cpu.addr_valid, cpu.opcode_fetch, cpu.insn_boundary} = 3'b001;
      cyc(1);
      cpu.insn_boundary = 1'b0;
      cyc(4);
      `CHK(n_fo - c0, (i == 3) ? 1 : 0, "forced breakpoint count")
      `CHK(n_tg - c1, (i == 2) ? 1 : 0, "tagged breakpoint count")
    end
    $display("breakpoint test done");
    host.xfer(SDCSB_CMD_WRITE_CONTROL, 16'h0080, r, v);
    cpu.in_lowpower = 1'b1;
    cyc(3);
    rd(SDCSB_CMD_READ_STATUS, r);
    `CHK(r[7:0], exp_st(8'h80, 1'b0, 1'b1, 1'b0), "low-power status")
    cpu.mem_cmd_fail = 1'b1;
    cyc(1);
    cpu.mem_cmd_fail = 1'b0;
    cyc(2);
    rd(SDCSB_CMD_READ_STATUS, r);
    `CHK(r[7:0], exp_st(8'h80, 1'b0, 1'b1, 1'b1), "conflict status")
    c2 = n_bg;
    host.xfer(SDCSB_CMD_FORCE_BGND, 16'h0000, r, v);
    cyc(2);
    `CHK(n_bg - c2, 1, "wake from low power")
    {cpu.in_lowpower, cpu.in_debug} = 2'b01;
    cyc(2);
    rd(SDCSB_CMD_READ_STATUS, r);
    `CHK(r[7:0], exp_st(8'h80, 1'b1, 1'b1, 1'b1), "forced debug status")
    host.xfer(SDCSB_CMD_WRITE_CONTROL, 16'h0000, r, v);
    `CHK(endbg, 1'b1, "enable kept in debug")
    cpu.in_debug = 1'b0;
    cyc(2);
    rd(SDCSB_CMD_READ_STATUS, r);
    `CHK(r[7:0], exp_st(8'h80, 1'b0, 1'b0, 1'b1), "user run status")
    host.xfer(SDCSB_CMD_WRITE_CONTROL, 16'h0000, r, v);
    c2 = n_bg;
    host.xfer(SDCSB_CMD_FORCE_BGND, 16'h0000, r, v);
    cyc(3);
    `CHK(n_bg - c2, 0, "force without enable")
    $display("low-power test done");
    c2 = n_rs;
    {uwr, uwd} = {1'b1, 8'hFF};
    cyc(1);
    uwr = 1'b0;
    host.xfer(SDCSB_CMD_WRITE_FRCRST, 16'hFFFE, r, v);
    cyc(8);
    `CHK(n_rs - c2, 0, "no reset from user or bit0 clear")
    host.xfer(SDCSB_CMD_WRITE_FRCRST, 16'h0001, r, v);
    cyc(8);
    `CHK(n_rs - c2, int'(FR_PULSE_CYCLES), "reset pulse width")
    rd(SDCSB_CMD_READ_FRCRST, r);
    `CHK(r, 16'h0000, "force-reset reads zero")
    $display("force reset test done");
    report_and_stop();
  end
endmodule // sdcsb_status_bkpt_tb
`default_nettype wire

//--- rtl/sdcsb_bkpt_match.sv
`timescale 1ns/10ps
`default_nettype none
module sdcsb_bkpt_match
  import sdcsb_pkg::*;
#(
  parameter int unsigned ADDR_W = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_enable,
  input wire logic i_force_sel,
  input wire logic [ADDR_W-1:0] i_match_addr,
  input wire sdcsb_cpu_t i_cpu,
  output logic o_force_req,
  output logic o_tag_req
);
  logic hit;
  logic force_pend_reg, force_pend_next;

  assign hit = i_enable && i_cpu.addr_valid && (i_cpu.addr == i_match_addr);

  always_comb begin
    force_pend_next = force_pend_reg;
    if (!i_enable) begin
      force_pend_next = 1'b0;
    end else if (i_cpu.insn_boundary) begin
      force_pend_next = 1'b0;
    end else if (hit && i_force_sel) begin
      force_pend_next = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      force_pend_reg <= 1'b0;
    end else if (i_ce) begin
      force_pend_reg <= force_pend_next;
    end
  end

  // Forced request fires at the boundary after any access to the address
  assign o_force_req = i_enable && i_force_sel && i_cpu.insn_boundary &&
                       (force_pend_reg || hit);
  // Tag marks only fetched opcodes; the core holds the tag through its queue
  assign o_tag_req = hit && !i_force_sel && i_cpu.opcode_fetch;
endmodule // sdcsb_bkpt_match
`default_nettype wire

//--- rtl/sdcsb_status_bkpt.sv
`timescale 1ns/10ps
`default_nettype none
module sdcsb_status_bkpt
  import sdcsb_pkg::*;
#(
  parameter int unsigned ADDR_W = 16
) (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_CE,
  input wire sdcsb_req_t I_REQ,
  input wire sdcsb_cpu_t I_CPU,
  input wire logic I_USER_FRCRST_WR,
  input wire logic [7:0] I_USER_WDATA,
  output logic [15:0] O_RDATA,
  output logic O_RVALID,
  output logic O_FORCE_BGND,
  output logic O_BKPT_FORCE,
  output logic O_BKPT_TAG,
  output logic O_MCU_RESET,
  output logic O_ENABLE_DEBUG,
  output logic O_CLK_SEL
);
  logic [7:0] ctrl_reg, ctrl_next;
  logic [ADDR_W-1:0] bkpt_reg, bkpt_next;
  logic lowpower_reg, lowpower_next;
  logic conflict_reg, conflict_next;
  logic [15:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic fbgnd_reg, fbgnd_next;
  logic frc_reg, frc_next;
  logic bkf_reg, bkt_reg;
  logic [3:0] frc_cnt_reg, frc_cnt_next;
  logic bk_force, bk_tag;
  logic [7:0] status;
  logic woke_from_lowpower;

  assign woke_from_lowpower = lowpower_reg && I_CPU.in_debug;

  always_comb begin
    status = 8'h00;
    status[SC_ENABLE_DEBUG_BIT] = ctrl_reg[SC_ENABLE_DEBUG_BIT];
    status[SC_DEBUG_ACTIVE_BIT] = I_CPU.in_debug;
    status[SC_BKPT_EN_BIT] = ctrl_reg[SC_BKPT_EN_BIT];
    status[SC_FORCE_TAG_BIT] = ctrl_reg[SC_FORCE_TAG_BIT];
    status[SC_CLK_SEL_BIT] = ctrl_reg[SC_CLK_SEL_BIT];
    status[SC_LOWPOWER_BIT] = lowpower_reg;
    status[SC_CONFLICT_BIT] = conflict_reg;
    status[SC_SLOW_FAIL_BIT] = 1'b0;
  end

  always_comb begin
    ctrl_next = ctrl_reg;
    bkpt_next = bkpt_reg;
    lowpower_next = lowpower_reg;
    conflict_next = conflict_reg;
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    fbgnd_next = 1'b0;
    frc_next = 1'b0;
    frc_cnt_next = frc_cnt_reg;
    // Low-power flag holds after a forced exit until user code resumes
    if (I_CPU.in_lowpower) begin
      lowpower_next = 1'b1;
    end else if (!I_CPU.in_debug) begin
      lowpower_next = 1'b0;
    end
    if (I_CPU.in_lowpower && !I_CPU.in_debug && !lowpower_reg) begin
      conflict_next = 1'b0;
    end
    if (I_CPU.mem_cmd_fail) begin
      conflict_next = 1'b1;
    end
    if (I_REQ.valid) begin
      case (I_REQ.cmd)
        SDCSB_CMD_READ_STATUS: begin
          rdata_next = {8'h00, status};
          rvalid_next = 1'b1;
        end
        SDCSB_CMD_WRITE_CONTROL: begin
          // Only control bits take the write; status bits stay hardware-owned
          ctrl_next[SC_BKPT_EN_BIT] = I_REQ.wdata[SC_BKPT_EN_BIT];
          ctrl_next[SC_FORCE_TAG_BIT] = I_REQ.wdata[SC_FORCE_TAG_BIT];
          ctrl_next[SC_CLK_SEL_BIT] = I_REQ.wdata[SC_CLK_SEL_BIT];
          // Enable may not change while debug is active
          if (!I_CPU.in_debug) begin
            ctrl_next[SC_ENABLE_DEBUG_BIT] = I_REQ.wdata[SC_ENABLE_DEBUG_BIT];
          end
        end
        SDCSB_CMD_BREAKPOINT_READ_CMD: begin
          rdata_next = 16'(bkpt_reg);
          rvalid_next = 1'b1;
        end
        SDCSB_CMD_BREAKPOINT_WRITE_CMD: begin
          bkpt_next = I_REQ.wdata[ADDR_W-1:0];
        end
        SDCSB_CMD_FORCE_BGND: begin
          // Accepted in low-power too, waking CPU into debug mode
          fbgnd_next = ctrl_reg[SC_ENABLE_DEBUG_BIT];
        end
        SDCSB_CMD_WRITE_FRCRST: begin
          if (I_REQ.wdata[FR_FORCE_RESET_BIT]) begin
            frc_cnt_next = FR_PULSE_CYCLES;
          end
        end
        SDCSB_CMD_READ_FRCRST: begin
          // Write-only register: no stored bit ever reaches the read path
          rdata_next = {8'h00, FR_READ_VAL};
          rvalid_next = 1'b1;
        end
        default: begin
          rvalid_next = 1'b0;
        end
      endcase
    end
    // User-side writes to the force-reset register are dropped: I_USER_FRCRST_WR drives no logic here, only an assertion
    if (frc_cnt_reg != 4'h0) begin
      frc_cnt_next = frc_cnt_reg - 4'h1;
      frc_next = 1'b1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      ctrl_reg <= SC_RESET_VAL;
      bkpt_reg <= BKPT_RESET_VAL;
      lowpower_reg <= 1'b0;
      conflict_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      rvalid_reg <= 1'b0;
      fbgnd_reg <= 1'b0;
      frc_reg <= 1'b0;
      frc_cnt_reg <= 4'h0;
    end else if (I_CE) begin
      ctrl_reg <= ctrl_next;
      bkpt_reg <= bkpt_next;
      lowpower_reg <= lowpower_next;
      conflict_reg <= conflict_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      fbgnd_reg <= fbgnd_next;
      frc_reg <= frc_next;
      frc_cnt_reg <= frc_cnt_next;
    end
  end

  sdcsb_bkpt_match #(.ADDR_W(ADDR_W)) u_match (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_ce(I_CE),
    .i_enable(ctrl_reg[SC_BKPT_EN_BIT]),
    .i_force_sel(ctrl_reg[SC_FORCE_TAG_BIT]),
    .i_match_addr(bkpt_reg),
    .i_cpu(I_CPU),
    .o_force_req(bk_force),
    .o_tag_req(bk_tag)
  );

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      bkf_reg <= 1'b0;
      bkt_reg <= 1'b0;
    end else if (I_CE) begin
      bkf_reg <= bk_force;
      bkt_reg <= bk_tag;
    end
  end

  assign O_RDATA = rdata_reg;
  assign O_RVALID = rvalid_reg;
  assign O_FORCE_BGND = fbgnd_reg;
  assign O_BKPT_FORCE = bkf_reg;
  assign O_BKPT_TAG = bkt_reg;
  assign O_MCU_RESET = frc_reg;
  assign O_ENABLE_DEBUG = ctrl_reg[SC_ENABLE_DEBUG_BIT];
  assign O_CLK_SEL = ctrl_reg[SC_CLK_SEL_BIT];

  a_slow_fail_zero: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    O_RVALID && $past(I_REQ.cmd) == SDCSB_CMD_READ_STATUS && $past(I_CE) |-> O_RDATA[SC_SLOW_FAIL_BIT] == 1'b0)
    else $error("slow fail flag set");
  a_lowpower_sets: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_CE && I_CPU.in_lowpower |=> lowpower_reg)
    else $error("lowpower flag not set");
  a_conflict_sets: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_CE && I_CPU.mem_cmd_fail |=> conflict_reg)
    else $error("conflict flag not set");
  a_bkpt_write_read: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_CE && I_REQ.valid && I_REQ.cmd == SDCSB_CMD_BREAKPOINT_WRITE_CMD |=> bkpt_reg == $past(I_REQ.wdata[ADDR_W-1:0]))
    else $error("breakpoint write lost");
  a_bkpt_disabled: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_CE && !ctrl_reg[SC_BKPT_EN_BIT] |=> !O_BKPT_FORCE && !O_BKPT_TAG)
    else $error("breakpoint while disabled");
  a_force_reset_pulse: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_CE && I_REQ.valid && I_REQ.cmd == SDCSB_CMD_WRITE_FRCRST && I_REQ.wdata[0] && frc_cnt_reg == 4'h0
    ##1 I_CE |=> O_MCU_RESET)
    else $error("force reset missing");
  a_user_write_ignored: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_CE && I_USER_FRCRST_WR && !(I_REQ.valid && I_REQ.cmd == SDCSB_CMD_WRITE_FRCRST) && frc_cnt_reg == 4'h0
    |=> !O_MCU_RESET)
    else $error("user write caused reset");
  a_frcrst_read_zero: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_CE && I_REQ.valid && I_REQ.cmd == SDCSB_CMD_READ_FRCRST |=> O_RVALID && O_RDATA == 16'h0000)
    else $error("force reset read not zero");
  a_status_readonly: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_CE && I_REQ.valid && I_REQ.cmd == SDCSB_CMD_WRITE_CONTROL && !I_CPU.in_lowpower && !I_CPU.mem_cmd_fail
    && I_CPU.in_debug |=> lowpower_reg == $past(lowpower_reg) && conflict_reg == $past(conflict_reg))
    else $error("status bit written");
  a_debug_active: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_CE && I_REQ.valid && I_REQ.cmd == SDCSB_CMD_READ_STATUS |=> O_RDATA[SC_DEBUG_ACTIVE_BIT] == $past(I_CPU.in_debug))
    else $error("debug active wrong");
endmodule // sdcsb_status_bkpt
`default_nettype wire

//--- shared/sdcsb_pkg.sv
`default_nettype none
package sdcsb_pkg;
  // Status/control bit positions
  localparam int unsigned SC_ENABLE_DEBUG_BIT = 7;
  localparam int unsigned SC_DEBUG_ACTIVE_BIT = 6;
  localparam int unsigned SC_BKPT_EN_BIT = 5;
  localparam int unsigned SC_FORCE_TAG_BIT = 4;
  localparam int unsigned SC_CLK_SEL_BIT = 3;
  localparam int unsigned SC_LOWPOWER_BIT = 2;
  localparam int unsigned SC_CONFLICT_BIT = 1;
  localparam int unsigned SC_SLOW_FAIL_BIT = 0;
  localparam int unsigned FR_FORCE_RESET_BIT = 0;
  // Reset values
  localparam logic [7:0] SC_RESET_VAL = 8'h00;
  localparam logic [15:0] BKPT_RESET_VAL = 16'h0000;
  localparam logic [7:0] FR_READ_VAL = 8'h00;
  // Width of the force-reset pulse handed to the system reset logic
  localparam logic [3:0] FR_PULSE_CYCLES = 4'h4;

  // Serial command decoded by the protocol engine
  typedef enum logic [2:0] {
    SDCSB_CMD_NONE,
    SDCSB_CMD_READ_STATUS,
    SDCSB_CMD_WRITE_CONTROL,
    SDCSB_CMD_BREAKPOINT_READ_CMD,
    SDCSB_CMD_BREAKPOINT_WRITE_CMD,
    SDCSB_CMD_FORCE_BGND,
    SDCSB_CMD_WRITE_FRCRST,
    SDCSB_CMD_READ_FRCRST
  } sdcsb_cmd_t;

  typedef struct packed {
    logic valid;
    sdcsb_cmd_t cmd;
    logic [15:0] wdata;
  } sdcsb_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic addr_valid;
    logic opcode_fetch;
    logic insn_boundary;
    logic in_lowpower;
    logic in_debug;
    logic mem_cmd_fail;
  } sdcsb_cpu_t;
endpackage : sdcsb_pkg
`default_nettype wire
